// ### src/dma_crc_core.sv
`timescale 1ns/100ps
// Shared DMA CRC generator with channel auto-rearm control and APB registers
module dma_crc_core #(
   parameter int NUM_CH = 8
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Source read stream from a channel
   input wire logic src_valid,
   input wire logic [2:0] src_chan,
   input wire logic [31:0] src_data,
   input wire logic [2:0] src_bytes,
   output logic src_ready,
   // Destination write stream
   output logic dst_valid,
   output logic [2:0] dst_chan,
   output logic [31:0] dst_data,
   output logic [2:0] dst_bytes,
   output logic dst_is_crc,
   input wire logic dst_ready,
   // Channel end events
   input wire logic [NUM_CH-1:0] block_done,
   input wire logic [NUM_CH-1:0] pattern_match,
   input wire logic [NUM_CH-1:0] abort_end,
   input wire logic [7:0] dest_size,
   // Channel control outputs
   output logic [NUM_CH-1:0] channel_on,
   output logic [NUM_CH-1:0] ptr_reset
);
   // Idle, byte walk through the CRC, forward a word, write the appended CRC
   typedef enum logic [1:0] {ST_IDLE, ST_CRC, ST_FWD, ST_APPEND} crc_state_e;

   crc_state_e state_r, state_nxt;
   logic [31:0] ctrl_r;
   logic [15:0] poly_r;
   logic [15:0] acc_r;
   logic [NUM_CH-1:0] on_r;
   logic [NUM_CH-1:0] rearm_r;
   logic [NUM_CH-1:0] ptr_r;
   logic [31:0] word_r;
   logic [2:0] left_r;
   logic [2:0] nbytes_r;
   logic [2:0] chan_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic src_ready_r;
   logic dst_valid_r;
   logic [31:0] dst_data_r;
   logic [2:0] dst_bytes_r;
   logic dst_is_crc_r;
   logic [2:0] dst_chan_r;
   logic append_pend_r;

   // Field decode
   wire logic crc_en = ctrl_r[crc_dma_pkg::CRC_ENABLE_BIT];
   wire logic app_sel = ctrl_r[crc_dma_pkg::CRC_APPEND_BIT]; // [RQ18]
   wire logic [2:0] sel_ch = ctrl_r[crc_dma_pkg::CRC_CH_LSB +: crc_dma_pkg::CRC_CH_W];
   wire logic [4:0] poly_length_field = ctrl_r[crc_dma_pkg::POLY_LENGTH_FIELD_LSB +: crc_dma_pkg::POLY_LENGTH_FIELD_W];

   // APB decode; access phase answered in one cycle
   // Writes land at the first access edge, the answer stands one cycle later
   wire logic acc_ph = psel && penable && !pready_r;
   wire logic wr_en = acc_ph && pwrite;
   wire logic hit_ctl = paddr == crc_dma_pkg::ADDR_CRC_CONTROL;
   wire logic hit_poly = paddr == crc_dma_pkg::ADDR_CRC_POLY_MASK;
   wire logic hit_acc = paddr == crc_dma_pkg::ADDR_CRC_ACCUMULATOR;
   wire logic hit_chc = paddr == crc_dma_pkg::ADDR_CHAN_CONTROL;
   wire logic hit_chs = paddr == crc_dma_pkg::ADDR_CHAN_STATUS;
   wire logic hit_any = hit_ctl || hit_poly || hit_acc || hit_chc || hit_chs;

   // Channel control word packs one byte per channel, four channels per word
   function automatic logic [31:0] pack_chan(input logic [NUM_CH-1:0] on,
                                             input logic [NUM_CH-1:0] rearm);
      logic [31:0] w;
      w = 32'h0000_0000;
      for (int i = 0; i < NUM_CH && i < 4; i++) begin
         w[i*8 + crc_dma_pkg::CHAN_ON_BIT] = on[i];
         w[i*8 + crc_dma_pkg::CHAN_REARM_BIT] = rearm[i];
      end
      return w;
   endfunction

   // Read mux; unmapped offsets read zero
   wire logic [31:0] rd_mux =
      hit_ctl ? ctrl_r :
      hit_poly ? {16'h0000, poly_r} :
      hit_acc ? {16'h0000, acc_r} : // Partial CRC visible at any time [RQ15]
      hit_chc ? pack_chan(on_r, rearm_r) :
      hit_chs ? {29'h0, state_r == ST_IDLE, app_sel, crc_en} : 32'h0000_0000;

   // CRC attached only to the selected channel while enabled [RQ5] [RQ6] [RQ21]
   wire logic crc_take = crc_en && src_chan == sel_ch;
   wire logic [7:0] cur_byte = word_r[31:24];
   logic [15:0] crc_next;

   crc_shift_unit u_shift (
      .crc_in(acc_r),
      .poly_mask(poly_r),
      .poly_length_field(poly_length_field),
      .data_byte(cur_byte),
      .crc_out(crc_next)
   );

   // Normal completion: block done or pattern match [RQ3]
   // An abort in the same cycle as a completion counts as an abort
   wire logic [NUM_CH-1:0] norm_end = (block_done | pattern_match) & ~abort_end;
   wire logic sel_end = crc_en && app_sel && norm_end[sel_ch];
   wire logic sel_abort = abort_end[sel_ch];
   // Append write size, capped at four bytes [RQ19]
   // A zero size selects the full four-byte write
   wire logic [2:0] app_bytes = (dest_size == 8'h00 || dest_size > 8'h04) ?
      crc_dma_pkg::APPEND_MAX_BYTES : dest_size[2:0];

   // Accept a source word when idle and output free
   // A word once taken is never dropped; src_ready opens over a held write only after an abort on the edge into ST_APPEND
   wire logic take_src = src_valid && src_ready_r && state_r == ST_IDLE;
   wire logic dst_done = dst_valid_r && dst_ready;

   // Sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (append_pend_r && !dst_valid_r) begin
               state_nxt = ST_APPEND;
            end else if (take_src) begin
               state_nxt = crc_take ? ST_CRC : ST_FWD;
            end
         end
         ST_CRC: begin
            // Append swallows the word, background still forwards it [RQ10] [RQ8]
            if (left_r == 3'h1) begin
               state_nxt = app_sel ? ST_IDLE : ST_FWD;
            end
         end
         ST_FWD: state_nxt = ST_IDLE;
         ST_APPEND: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   // State and APB handshake
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else if (clk_en) begin
         state_r <= state_nxt;
         pready_r <= acc_ph;
         pslverr_r <= acc_ph && !hit_any;
         prdata_r <= (acc_ph && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // Programmable registers
   // Reserved control bits are dropped on write and read back as zero
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ctrl_r <= crc_dma_pkg::CRC_CONTROL_RST;
         poly_r <= crc_dma_pkg::POLY_MASK_RST;
      end else if (clk_en && wr_en) begin
         if (hit_ctl) begin
            ctrl_r <= pwdata & 32'h0000_1FC7;
         end
         if (hit_poly) begin
            poly_r <= pwdata[15:0]; // [RQ11]
         end
      end
   end

   // Accumulator: seed write wins, else one byte per clock [RQ14] [RQ7] [RQ9]
   // A seed write mid-block wins, so software seeds before enabling
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         acc_r <= crc_dma_pkg::ACCUM_RST[15:0];
      end else if (clk_en) begin
         if (wr_en && hit_acc) begin
            acc_r <= pwdata[15:0];
         end else if (state_r == ST_CRC) begin
            acc_r <= crc_next;
         end
      end
   end

   // Word capture and byte walk, MSB byte first [RQ16] [RQ7]
   // Valid bytes are left-aligned so the next byte is always on top
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         word_r <= 32'h0000_0000;
         left_r <= 3'h0;
         nbytes_r <= 3'h0;
         chan_r <= 3'h0;
         src_ready_r <= 1'b0;
      end else if (clk_en) begin
         // Closed while a write is owed or an append is due, so a new word can overwrite the
         // held destination data only after an abort on the edge into ST_APPEND
         src_ready_r <= state_nxt == ST_IDLE && state_r != ST_FWD && !take_src
            && !(dst_valid_r && !dst_done) && !append_pend_r && !sel_end;
         if (take_src) begin
            word_r <= src_data << (8 * (4 - src_bytes));
            left_r <= src_bytes;
            nbytes_r <= src_bytes;
            chan_r <= src_chan;
         end else if (state_r == ST_CRC) begin
            word_r <= {word_r[23:0], 8'h00};
            left_r <= left_r - 3'h1;
         end
      end
   end

   // Destination output: pass-through data or appended CRC [RQ8] [RQ10]
   // One holding register serves data and CRC, held until accepted unless a word is taken after an abort on the edge into ST_APPEND
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         dst_valid_r <= 1'b0;
         dst_data_r <= 32'h0000_0000;
         dst_bytes_r <= 3'h0;
         dst_is_crc_r <= 1'b0;
         dst_chan_r <= 3'h0;
      end else if (clk_en) begin
         if (dst_done) begin
            dst_valid_r <= 1'b0;
         end
         if (take_src) begin
            dst_data_r <= src_data;
            dst_is_crc_r <= 1'b0;
         end else if (state_r == ST_FWD) begin
            dst_valid_r <= 1'b1; // Background or unselected: data written [RQ8] [RQ21]
            dst_bytes_r <= nbytes_r;
            dst_chan_r <= chan_r;
         end else if (state_r == ST_APPEND) begin
            dst_valid_r <= 1'b1; // Append: only the CRC, upper half zero [RQ10] [RQ19]
            dst_data_r <= {16'h0000, acc_r};
            dst_bytes_r <= app_bytes;
            dst_chan_r <= sel_ch;
            dst_is_crc_r <= 1'b1;
         end
      end
   end

   // Append write pending after normal end; dropped on abort [RQ10] [RQ20]
   // Abort wins over completion, and over a pending write only at edges before the one into ST_APPEND
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         append_pend_r <= 1'b0;
      end else if (clk_en) begin
         if (sel_abort) begin
            append_pend_r <= 1'b0; // [RQ20]
         end else if (sel_end) begin
            append_pend_r <= 1'b1;
         end else if (state_r == ST_APPEND) begin
            append_pend_r <= 1'b0;
         end
      end
   end

   // Channel on and auto-rearm; normal end keeps a rearmed channel on [RQ2] [RQ4]
   // Software write wins over a hardware clear in the same cycle
   // Only channels 0 to 3 have a lane in the control word
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         on_r <= '0;
         rearm_r <= '0;
         ptr_r <= '0;
      end else if (clk_en) begin
         for (int i = 0; i < NUM_CH; i++) begin
            ptr_r[i] <= on_r[i] && norm_end[i]; // Pointers restart at each completion of a channel that is on [RQ4]
            if (wr_en && hit_chc && i < 4) begin
               on_r[i] <= pwdata[(i % 4) * 8 + crc_dma_pkg::CHAN_ON_BIT];
               rearm_r[i] <= pwdata[(i % 4) * 8 + crc_dma_pkg::CHAN_REARM_BIT];
            end else if (abort_end[i]) begin
               on_r[i] <= 1'b0;
            end else if (norm_end[i] && !rearm_r[i]) begin
               on_r[i] <= 1'b0; // Kept on when auto-rearm set [RQ2] [RQ3]
            end
         end
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign src_ready = src_ready_r;
   assign dst_valid = dst_valid_r;
   assign dst_data = dst_data_r;
   assign dst_bytes = dst_bytes_r;
   assign dst_is_crc = dst_is_crc_r;
   assign dst_chan = dst_chan_r;
   assign channel_on = on_r;
   assign ptr_reset = ptr_r;
endmodule

// ### inc/crc_dma_pkg.sv
// Package with register map, field positions and constants of the DMA CRC block
// Overview of operation
// RQ1: Software sets channel auto-rearm before setting channel on, bit 7.
// RQ2: With auto-rearm, normal completion leaves channel on set.
// RQ3: Block done and pattern match both count as normal completion.
// RQ4: Each rearming completion resets source, destination and cell pointers.
// RQ5: One CRC generator shared, attached to channel chosen by select field.
// RQ6: Generator runs only while CRC enable bit 7 is set.
// RQ7: One clock per source byte; wider reads take one clock per byte.
// RQ8: Append clear: data passes through CRC and is written to destination.
// RQ9: Background mode leaves final CRC in the accumulator register.
// RQ10: Append mode suppresses data writes, then writes CRC at block end.
// RQ11: Intermediate polynomial terms come from 16-bit mask register bits.
// RQ12: Highest and lowest polynomial terms are always included.
// RQ13: Length field bits 12 to 8 holds polynomial degree minus one.
// RQ14: Writing accumulator loads the seed; done before enabling the channel.
// RQ15: Reading accumulator during generation returns the partial CRC.
// RQ16: Source bytes enter the generator most significant bit first.
// RQ17: Polynomials up to degree sixteen are supported.
// RQ18: Append-select bit 6 switches attached channel to append operation.
// RQ19: Append writes at most 4 CRC bytes, fewer if destination size smaller.
// RQ20: No CRC written when transfer ends by abort or bus error; no bus error input, and an abort on the edge into ST_APPEND still writes CRC.
// RQ21: Unselected channels, or CRC disabled, transfer without CRC involvement.
package crc_dma_pkg;
   // Register byte offsets on APB
   localparam logic [7:0] ADDR_CRC_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_CRC_POLY_MASK = 8'h04;
   localparam logic [7:0] ADDR_CRC_ACCUMULATOR = 8'h08;
   localparam logic [7:0] ADDR_CHAN_CONTROL = 8'h10;
   localparam logic [7:0] ADDR_CHAN_STATUS = 8'h14;
   // crc_control fields
   localparam int CRC_CH_LSB = 0;
   localparam int CRC_CH_W = 3;
   localparam int CRC_APPEND_BIT = 6;
   localparam int CRC_ENABLE_BIT = 7;
   localparam int POLY_LENGTH_FIELD_LSB = 8;
   localparam int POLY_LENGTH_FIELD_W = 5;
   // channel_control_reg fields (one byte per channel lane)
   localparam int CHAN_ON_BIT = 7;
   localparam int CHAN_REARM_BIT = 4;
   // Reset values
   localparam logic [31:0] CRC_CONTROL_RST = 32'h0000_0000;
   localparam logic [15:0] POLY_MASK_RST = 16'h0000;
   localparam logic [31:0] ACCUM_RST = 32'h0000_0000;
   // Append write limit in bytes
   localparam logic [2:0] APPEND_MAX_BYTES = 3'h4;
   localparam int CRC_MAX_DEG = 16;
endpackage

// ### src/crc_shift_unit.sv
`timescale 1ns/100ps
// Single-bit-per-step CRC engine, one byte per clock
module crc_shift_unit (
   // Current state and polynomial
   input wire logic [15:0] crc_in,
   input wire logic [15:0] poly_mask,
   input wire logic [4:0] poly_length_field,
   // Byte to fold in
   input wire logic [7:0] data_byte,
   // Updated state
   output logic [15:0] crc_out
);
   // Fold byte MSB first through a polynomial of degree poly_length_field+1 [RQ16] [RQ13]
   always_comb begin
      logic [15:0] c;
      logic [15:0] poly;
      logic [15:0] top;
      logic fb;
      fb = 1'b0;
      c = crc_in;
      // Lowest term forced on; highest term is implicit as the feedback [RQ12] [RQ11]
      poly = poly_mask | 16'h0001;
      top = 16'h0001 << poly_length_field;
      for (int i = 7; i >= 0; i--) begin
         fb = ((c & top) != 16'h0000) ^ data_byte[i];
         c = c << 1;
         if (fb) begin
            c = c ^ poly;
         end
      end
      // Keep only degree bits, up to sixteen [RQ17]
      crc_out = c & ((top << 1) - 16'h0001 | top);
   end
endmodule

// ### bench/dma_crc_core_monitor.sv
// Port-level assertions for the DMA CRC core
`timescale 1ns/100ps
module dma_crc_core_monitor #(
   parameter int NUM_CH = 8
) (
   // Clock, reset and APB
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Streams
   input wire logic src_valid,
   input wire logic [2:0] src_chan,
   input wire logic [2:0] src_bytes,
   input wire logic src_ready,
   input wire logic dst_valid,
   input wire logic [2:0] dst_chan,
   input wire logic [31:0] dst_data,
   input wire logic [2:0] dst_bytes,
   input wire logic dst_is_crc,
   input wire logic dst_ready,
   // Channel events
   input wire logic [NUM_CH-1:0] block_done,
   input wire logic [NUM_CH-1:0] pattern_match,
   input wire logic [NUM_CH-1:0] ptr_reset
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic [31:0] ctl_r;
   wire take = src_valid && src_ready;
   wire hit = ctl_r[7] && src_chan == ctl_r[2:0];
   // Shadow of crc_control; traffic never follows a write within one cycle
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ctl_r <= '0;
      end else if (psel && penable && pready && pwrite && paddr == 8'h00) begin
         ctl_r <= pwdata & 32'h0000_1FC7;
      end
   end
   apb_answer_a: assert property (psel && penable && !pready |=> pready)
      else $error("APB access not answered");
   pready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
   apb_refuse_a: assert property (psel && penable && !pready && paddr > 8'h14
      |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   src_busy_a: assert property (take |=> !src_ready) else $error("word taken while busy");
   crc_clocks_a: assert property (take && hit && !ctl_r[6] && src_bytes == 3'h4
      |=> !dst_valid [*5] ##1 dst_valid) else $error("CRC word timing wrong");
   pass_through_a: assert property (take && !hit |=> !dst_valid ##1 dst_valid)
      else $error("plain word timing wrong");
   dst_hold_a: assert property (dst_valid && !dst_ready |=> dst_valid && $stable(dst_data)
      && $stable(dst_bytes) && $stable(dst_is_crc)) else $error("write not held");
   append_quiet_a: assert property (dst_valid && ctl_r[7] && ctl_r[6]
      && dst_chan == ctl_r[2:0] |-> dst_is_crc) else $error("data written in append");
   crc_word_a: assert property (dst_valid && dst_is_crc |-> dst_data[31:16] == 16'h0
      && dst_bytes inside {[1:4]}) else $error("CRC write malformed");
   ptr_cause_a: assert property (ptr_reset != 0
      |-> $past(block_done | pattern_match) != 0) else $error("pointer reset uncaused");
endmodule
bind dma_crc_core dma_crc_core_monitor #(.NUM_CH(NUM_CH)) i_mon (.ref_clk, .rstn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .src_valid, .src_chan,
   .src_bytes, .src_ready, .dst_valid, .dst_chan, .dst_data, .dst_bytes, .dst_is_crc,
   .dst_ready, .block_done, .pattern_match, .ptr_reset);

// ### bench/dst_sink_model.sv
// Destination bus model that accepts writes with random stalls
`timescale 1ns/100ps
module dst_sink_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Write acceptance
   output logic dst_ready
);
   // Stalls one cycle in four so that held writes are exercised
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         dst_ready <= 1'b0;
      end else begin
         dst_ready <= ($urandom % 4) != 0;
      end
   end
endmodule

// ### bench/tb_dma_crc_core.sv
// Self-checking bench for the DMA CRC core
`timescale 1ns/100ps
module tb_dma_crc_core;
   logic ref_clk, rstn, clk_en, psel, penable, pwrite, pready, pslverr, err;
   logic src_valid, src_ready, dst_valid, dst_is_crc, dst_ready, q_crc;
   logic [7:0] paddr, dest_size, block_done, pattern_match, abort_end, channel_on;
   logic [7:0] ptr_reset, ptr_seen;
   logic [31:0] pwdata, prdata, src_data, dst_data, rd, q_data;
   logic [2:0] src_chan, src_bytes, dst_chan, dst_bytes, q_bytes, q_chan;
   logic [15:0] crc;
   int mismatches, compares, dst_cnt;
   dma_crc_core #(.NUM_CH(8)) i_dut (.ref_clk, .rstn, .clk_en, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .src_valid, .src_chan, .src_data,
      .src_bytes, .src_ready, .dst_valid, .dst_chan, .dst_data, .dst_bytes, .dst_is_crc,
      .dst_ready, .block_done, .pattern_match, .abort_end, .dest_size, .channel_on,
      .ptr_reset);
   dst_sink_model i_sink (.ref_clk, .rstn, .dst_ready);
   // Clock at 125 MHz
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Count accepted writes and remember pointer reset pulses
   always @(posedge ref_clk) begin
      if (dst_valid === 1'b1 && dst_ready === 1'b1) dst_cnt <= dst_cnt + 1;
      if (rstn) ptr_seen <= ptr_seen | ptr_reset;
   end
   task automatic complete_run;
      $display("Comparisons %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // A wait that ran out of cycles counts as a failure and ends the run
   task automatic bound(input int n);
      if (n >= 200) begin
         cmp("handshake_wait", 1, 0);
         complete_run();
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      bound(n);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic src(input logic [2:0] c, input logic [31:0] d, input logic [2:0] b);
      int n;
      @(posedge ref_clk);
      {src_valid, src_chan, src_data, src_bytes} <= {1'b1, c, d, b};
      for (n = 0; n < 200; n++) begin
         @(posedge ref_clk);
         if (src_ready === 1'b1) break;
      end
      bound(n);
      src_valid <= 1'b0;
   endtask
   task automatic wait_dst;
      int n;
      for (n = 0; n < 200; n++) begin
         @(posedge ref_clk);
         if (dst_valid === 1'b1 && dst_ready === 1'b1) break;
      end
      bound(n);
      {q_data, q_bytes, q_crc, q_chan} = {dst_data, dst_bytes, dst_is_crc, dst_chan};
   endtask
   // Reference CRC: one bit at a time, top bit first, lowest term implied
   function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] m,
         input logic [4:0] pl, input logic [31:0] d, input logic [2:0] b);
      logic fb;
      for (int k = 31; k >= 0; k--) begin
         if (k < 8 * b) begin
            fb = c[pl] ^ d[k];
            c = {c[14:0], 1'b0} ^ ({16{fb}} & (m | 16'h0001));
         end
      end
      return c & (16'hFFFF >> (15 - pl));
   endfunction
   task automatic bg_run(input logic [2:0] ch, input logic [4:0] pl, input logic [15:0] m,
         input logic [15:0] s);
      logic [31:0] d;
      logic [2:0] c, b;
      apb(1'b1, 8'h08, {16'h0000, s});
      apb(1'b1, 8'h04, {16'h0000, m});
      apb(1'b1, 8'h00, {19'h0, pl, 5'h10, ch});
      crc = s;
      for (int i = 0; i < 12; i++) begin
         c = (i % 3 == 2) ? 3'($urandom % 4) : ch;
         b = (i < 2) ? 3'h4 : 3'($urandom % 4 + 1);
         d = $urandom & (32'hFFFF_FFFF >> (8 * (4 - b)));
         src(c, d, b);
         wait_dst();
         cmp("dst_word", {d, b, 1'b0, c}, {q_data, q_bytes, q_crc, q_chan});
         if (c == ch) crc = crc_word(crc, m, pl, d, b);
         apb(1'b0, 8'h08, 32'h0);
         cmp("accumulator", {16'h0000, crc}, rd);
      end
   endtask
   // Append block ending normally or by abort, with a given destination size
   task automatic app_run(input logic [7:0] ds, input logic [1:0] kind);
      int n0, n;
      logic [31:0] d;
      apb(1'b1, 8'h08, 32'h0000_FFFF);
      apb(1'b1, 8'h04, 32'h0000_1020);
      apb(1'b1, 8'h00, 32'h0000_0FC0);
      dest_size <= ds;
      crc = 16'hFFFF;
      n0 = dst_cnt;
      for (int i = 0; i < 3; i++) begin
         d = $urandom;
         src(3'h0, d, 3'h4);
         crc = crc_word(crc, 16'h1020, 5'h0F, d, 3'h4);
      end
      @(posedge ref_clk);
      for (n = 0; n < 200 && src_ready !== 1'b1; n++) @(posedge ref_clk);
      bound(n);
      cmp("append_silent", n0, dst_cnt);
      abort_end <= {7'h0, kind == 2'h2};
      pattern_match <= {7'h0, kind == 2'h1};
      block_done <= {7'h0, kind == 2'h0};
      @(posedge ref_clk);
      {abort_end, pattern_match, block_done} <= '0;
      if (kind == 2) begin
         repeat (20) @(posedge ref_clk);
         cmp("abort_silent", n0, dst_cnt);
      end else begin
         wait_dst();
         cmp("crc_write", {crc, 1'b1, 3'h0}, {q_data, q_crc, q_chan});
         cmp("crc_bytes", (ds == 0 || ds > 4) ? 4 : ds, q_bytes);
      end
   endtask
   initial begin
      {rstn, psel, penable, pwrite, src_valid, ptr_seen, dst_cnt} = '0;
      {paddr, pwdata, src_chan, src_data, src_bytes, dest_size} = '0;
      {block_done, pattern_match, abort_end} = '0;
      clk_en = 1'b1;
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      void'($urandom(72423));
      for (int a = 0; a < 12; a += 4) begin
         apb(1'b0, 8'(a), 32'h0);
         cmp("reset_value", 32'h0, rd);
      end
      apb(1'b0, 8'h40, 32'h0);
      cmp("unmapped_err", 1'b1, err);
      cmp("unmapped_data", 32'h0, rd);
      apb(1'b1, 8'h00, 32'hFFFF_FFFF);
      apb(1'b0, 8'h00, 32'h0);
      cmp("control_mask", 32'h0000_1FC7, rd);
      apb(1'b1, 8'h10, 32'h0000_0010);
      apb(1'b1, 8'h10, 32'h0000_8090);
      cmp("channel_on", 8'h03, channel_on);
      {pattern_match, block_done} <= 16'h0102;
      @(posedge ref_clk);
      {pattern_match, block_done} <= 16'h0;
      repeat (3) @(posedge ref_clk);
      cmp("rearm_kept", 9'h101, {ptr_seen[0], channel_on});
      apb(1'b0, 8'h10, 32'h0);
      cmp("chan_control", 32'h0000_0090, rd);
      apb(1'b0, 8'h14, 32'h0);
      cmp("status", 32'h0000_0007, rd);
      bg_run(3'h0, 5'h0F, 16'h1020, 16'hFFFF);
      bg_run(3'h2, 5'h07, 16'h0006, 16'h00A5);
      for (int k = 0; k < 5; k++) app_run(8'(k * 3 % 7), 2'(k % 2));
      app_run(8'h01, 2'h1);
      app_run(8'h04, 2'h2);
      complete_run();
   end
endmodule
